// *** bench/can_control_status_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ccs_regs.svh"
module can_control_status_regs_test;
  localparam logic [7:0] ctl = `CCS_IDX_CTRL;
  localparam logic [7:0] sts = `CCS_IDX_STAT;
  localparam logic [7:0] iqr = `CCS_IDX_IRQ;
  localparam logic [7:0] cfg [6] = '{`CCS_IDX_CFG0, `CCS_IDX_CFG1, `CCS_IDX_CFG2,
                                     `CCS_IDX_CFG3, `CCS_IDX_CFG4, `CCS_IDX_CFG5};
  logic                   clk, arst_n, psel, pen, pwr, slv, pready, pslverr, irq, txa, txb;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic [3:0]             pstrb;
  logic [7:0]             q;
  int                     err_count, checks;
  ccs_pkg::ccs_evt_t      evt;
  ccs_pkg::ccs_core_ctl_t cctl;
  ccs_ctrl_status i_ccs_ctrl_status (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .I_EVT(evt), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_IRQ(irq), .O_TX_OUT_A(txa),
    .O_TX_OUT_B(txb), .O_CORE_CTL(cctl)
  );
  ccs_can_node i_ccs_can_node (.i_ctl(cctl), .i_clk(clk), .o_evt(evt));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic ccs_pkg::ccs_evt_t ev(input int k, input logic [2:0] c);
    ev = '0;
    case (k)
      0: ev.rx_ok = 1'h1;
      1: ev.tx_ok = 1'h1;
      2: ev.err_valid = 1'h1;
      3: ev.idle11 = 1'h1;
      4: ev.bus_activity = 1'h1;
      5: ev.sleep = 1'h1;
      6: ev.tx_bit = 1'h1;
      7: ev.in_arbitration = 1'h1;
      9: ev.power_down = 1'h1;
      default: ev.frame_active = 1'h1;
    endcase
    ev.err_code = c;
  endfunction
  task automatic results;
    $display("mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    chk("pready", pready, 1'h1);
    if (n >= 16) results;
    q = prdata[7:0];
    slv = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    apb(1'h0, i, 8'h00);
    chk("read data", q, e);
  endtask
  task automatic wirq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk("irq", irq, v);
    if (n >= 8) results;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(ctl, 8'h01);
    apb(1'h0, 8'h03, 8'h00);
    chk("slverr", slv, 1'h1);
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, ctl, k ? 8'h41 : 8'h01);
      foreach (cfg[j]) begin
        apb(1'h1, cfg[j], 8'hA5);
        rd(cfg[j], k ? 8'hA5 : 8'h00);
      end
    end
    apb(1'h1, ctl, 8'h01);
    apb(1'h1, cfg[5], 8'h5A);
    rd(cfg[5], 8'hA5);
  endtask
  task automatic t_hold;
    i_ccs_can_node.set(ev(6, 3'h0), 1'h0);
    repeat (2) @(posedge clk);
    chk("tx a", txa, 1'h1);
    chk("tx b", txb, 1'h0);
    apb(1'h1, ctl, 8'h00);
    repeat (4) @(posedge clk);
    chk("tx a", txa, 1'h1);
    i_ccs_can_node.pulse(ev(3, 3'h0));
    repeat (2) @(posedge clk);
    chk("tx b", txb, 1'h1);
    i_ccs_can_node.set(ev(8, 3'h0), 1'h1);
    apb(1'h1, ctl, 8'h01);
    repeat (2) @(posedge clk);
    chk("tx a", txa, 1'h0);
    chk("xfer", cctl.xfer_enable, 1'h0);
    i_ccs_can_node.set(ev(8, 3'h0), 1'h0);
    repeat (2) @(posedge clk);
    chk("tx a", txa, 1'h1);
    i_ccs_can_node.set(ev(6, 3'h0), 1'h1);
    apb(1'h1, ctl, 8'h00);
    i_ccs_can_node.pulse(ev(3, 3'h0));
  endtask
  task automatic t_flags;
    apb(1'h1, sts, 8'h00);
    for (int c = 1; c < 6; c++) begin
      i_ccs_can_node.frame(ev(2, c[2:0]), ev(2, 3'h1));
      rd(sts, c[7:0]);
    end
    apb(1'h1, sts, 8'h00);
    i_ccs_can_node.frame(ev(2, 3'h4) | ev(7, 3'h0), ev(2, 3'h5) | ev(7, 3'h0));
    rd(sts, 8'h00);
    i_ccs_can_node.frame(ev(2, 3'h2), ev(0, 3'h0));
    rd(sts, 8'h10);
    i_ccs_can_node.frame(ev(1, 3'h0), '0);
    rd(sts, 8'h18);
    apb(1'h1, sts, 8'hE7);
    rd(sts, 8'h07);
  endtask
  task automatic t_irq;
    apb(1'h1, ctl, 8'h04);
    i_ccs_can_node.frame(ev(0, 3'h0), '0);
    wirq(1'h0);
    rd(iqr, 8'h01);
    apb(1'h1, ctl, 8'h06);
    wirq(1'h1);
    rd(sts, 8'h10);
    wirq(1'h0);
    i_ccs_can_node.set(ev(5, 3'h0), 1'h1);
    i_ccs_can_node.pulse(ev(4, 3'h0));
    wirq(1'h1);
    i_ccs_can_node.set(ev(5, 3'h0), 1'h0);
    repeat (2) @(posedge clk);
    apb(1'h0, sts, 8'h00);
    chk("wake", q[5], 1'h1);
    wirq(1'h0);
    i_ccs_can_node.set(ev(9, 3'h0), 1'h1);
    i_ccs_can_node.set(ev(9, 3'h0), 1'h0);
    wirq(1'h1);
    rd(sts, 8'h30);
    wirq(1'h0);
  endtask
  task automatic t_err;
    apb(1'h1, ctl, 8'h0A);
    i_ccs_can_node.cnt(9'h060, 9'h000);
    wirq(1'h1);
    apb(1'h0, sts, 8'h00);
    chk("warn", q[6], 1'h1);
    i_ccs_can_node.cnt(9'h000, 9'h100);
    repeat (3) @(posedge clk);
    apb(1'h0, ctl, 8'h00);
    chk("init", q[0], 1'h1);
    apb(1'h1, ctl, 8'h0A);
    repeat (3) @(posedge clk);
    chk("rec", evt.rec, 9'h000);
    repeat (127) i_ccs_can_node.pulse(ev(3, 3'h0));
    apb(1'h0, sts, 8'h00);
    chk("code", q[2:0], 3'h5);
    chk("bus_off_flag", cctl.bus_off, 1'h1);
    i_ccs_can_node.pulse(ev(3, 3'h0));
    repeat (3) @(posedge clk);
    chk("bus_off_flag", cctl.bus_off, 1'h0);
  endtask
  initial begin
    err_count = 0;
    checks = 0;
    {arst_n, psel, pen, pwr, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    t_regs;
    t_hold;
    t_flags;
    t_irq;
    t_err;
    results;
  end
endmodule
`default_nettype wire

// *** bench/ccs_can_node.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_can_node (
  input  wire ccs_pkg::ccs_core_ctl_t i_ctl,
  input  wire logic                   i_clk,
  output ccs_pkg::ccs_evt_t           o_evt
);
  initial begin
    o_evt = '0;
    o_evt.tx_bit = 1'h1;
  end
  // counters restart on request
  always @(posedge i_clk) begin
    if (i_ctl.err_cnt_clear) begin
      o_evt.tec <= 9'h000;
      o_evt.rec <= 9'h000;
    end
  end
  task automatic set(input ccs_pkg::ccs_evt_t m, input logic v);
    @(posedge i_clk);
    o_evt <= v ? (o_evt | m) : (o_evt & ~m);
  endtask
  task automatic pulse(input ccs_pkg::ccs_evt_t m);
    set(m, 1'h1);
    set(m, 1'h0);
  endtask
  task automatic cnt(input logic [8:0] t, input logic [8:0] r);
    @(posedge i_clk);
    o_evt.tec <= t;
    o_evt.rec <= r;
  endtask
  // one frame, two events inside it
  task automatic frame(input ccs_pkg::ccs_evt_t m1, input ccs_pkg::ccs_evt_t m2);
    ccs_pkg::ccs_evt_t f;
    f = '0;
    f.frame_start = 1'h1;
    f.frame_active = 1'h1;
    set(f, 1'h1);
    f.frame_active = 1'h0;
    set(f, 1'h0);
    pulse(m1);
    pulse(m2);
    f.frame_active = 1'h1;
    set(f, 1'h0);
  endtask
endmodule
`default_nettype wire

// *** bench/ccs_ctrl_status_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccs_ctrl_status_properties (
  input wire logic                   I_CLK,
  input wire logic                   I_ARST_N,
  input wire logic                   I_PSEL,
  input wire logic                   I_PENABLE,
  input wire logic                   I_PWRITE,
  input wire logic [11:0]            I_PADDR,
  input wire logic [31:0]            I_PWDATA,
  input wire logic [3:0]             I_PSTRB,
  input wire logic                   O_PREADY,
  input wire logic [31:0]            O_PRDATA,
  input wire logic                   O_IRQ,
  input wire logic                   O_TX_OUT_A,
  input wire logic                   O_TX_OUT_B,
  input wire ccs_pkg::ccs_core_ctl_t O_CORE_CTL
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  wire logic rd = O_PREADY && !I_PWRITE;
  wire logic ie_off = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h000
                      && I_PSTRB[0] && !I_PWDATA[1];
  ////////////////////////////////////////////////////////////
  property p_ready;
    I_PSEL && !I_PENABLE |=> O_PREADY;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after setup");
  property p_bus_off_flag_tx;
    O_CORE_CTL.bus_off |-> O_TX_OUT_A && !O_TX_OUT_B;
  endproperty
  a_bus_off_flag_tx: assert property (p_bus_off_flag_tx)
    else $error("transmit not recessive in bus-off");
  property p_clr;
    O_CORE_CTL.err_cnt_clear |-> O_CORE_CTL.bus_off ##1 !O_CORE_CTL.err_cnt_clear;
  endproperty
  a_clr: assert property (p_clr)
    else $error("counter clear outside recovery start");
  property p_ie_off;
    ie_off |=> ##1 !O_IRQ;
  endproperty
  a_ie_off: assert property (p_ie_off)
    else $error("interrupt with global enable off");
  property p_rsv;
    rd && I_PADDR == 12'h000 |-> (O_PRDATA & 32'hFFFFFFB0) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved control bits not zero");
  property p_bus_off_flag_bit;
    rd && I_PADDR == 12'h004 |-> O_PRDATA[7] == $past(O_CORE_CTL.bus_off);
  endproperty
  a_bus_off_flag_bit: assert property (p_bus_off_flag_bit)
    else $error("bus-off flag differs from state");
  property p_irq_val;
    rd && I_PADDR == 12'h17C |-> O_PRDATA inside {32'h0, 32'h1};
  endproperty
  a_irq_val: assert property (p_irq_val)
    else $error("interrupt register value illegal");
  property p_rst;
    $rose(I_ARST_N) |-> O_TX_OUT_A && !O_TX_OUT_B && !O_IRQ && !O_CORE_CTL.xfer_enable;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs wrong after reset");
endmodule
bind ccs_ctrl_status ccs_ctrl_status_properties i_ccs_ctrl_status_properties (
  .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
  .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_IRQ(O_IRQ), .O_TX_OUT_A(O_TX_OUT_A),
  .O_TX_OUT_B(O_TX_OUT_B), .O_CORE_CTL(O_CORE_CTL)
);
`default_nettype wire

// *** verilog/ccs_ctrl_status.sv ***
`include "ccs_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ccs_ctrl_status (
  input  wire logic                  I_CLK,
  input  wire logic                  I_ARST_N,
  input  wire logic                  I_PSEL,
  input  wire logic                  I_PENABLE,
  input  wire logic                  I_PWRITE,
  input  wire logic [11:0]           I_PADDR,
  input  wire logic [31:0]           I_PWDATA,
  input  wire logic [3:0]            I_PSTRB,
  input  wire ccs_pkg::ccs_evt_t     I_EVT,
  output logic                       O_PREADY,
  output logic [31:0]                O_PRDATA,
  output logic                       O_PSLVERR,
  output logic                       O_IRQ,
  output logic                       O_TX_OUT_A,
  output logic                       O_TX_OUT_B,
  output ccs_pkg::ccs_core_ctl_t     O_CORE_CTL
);

  ////////////////////////////////////////////////////////////////////////////
  // config slot decode

  function automatic logic [3:0] cfg_slot(input logic [7:0] idx);
    logic [3:0] s;
    s = 4'h0;
    case (idx)
      `CCS_IDX_CFG0: s = 4'h8;
      `CCS_IDX_CFG1: s = 4'h9;
      `CCS_IDX_CFG2: s = 4'hA;
      `CCS_IDX_CFG3: s = 4'hB;
      `CCS_IDX_CFG4: s = 4'hC;
      `CCS_IDX_CFG5: s = 4'hD;
      default:       s = 4'h0;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]          ctrl_r;
  logic [7:0]          ctrl_nxt;
  logic                bus_off_flag_r;
  logic                bus_off_flag_nxt;
  logic                warn_r;
  logic                warn_nxt;
  logic                wake_r;
  logic                wake_nxt;
  logic                rx_success_flag_r;
  logic                rx_success_flag_nxt;
  logic                tx_success_flag_r;
  logic                tx_success_flag_nxt;
  logic [2:0]          lec_r;
  logic [2:0]          lec_nxt;
  logic                first_r;
  logic                first_nxt;
  logic                pend_r;
  logic                pend_nxt;
  logic                sleep_d_r;
  logic                pd_d_r;
  logic [6:0]          rcnt_r;
  logic [6:0]          rcnt_nxt;
  logic [7:0]          cfg_r [`CCS_CFG_NUM];
  ccs_pkg::ccs_state_t state_r;
  ccs_pkg::ccs_state_t state_nxt;

  logic                pready_r;
  logic [31:0]         prdata_r;
  logic                pslverr_r;
  logic                irq_r;
  logic                tx_a_r;
  logic                tx_b_r;
  ccs_pkg::ccs_core_ctl_t core_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire       setup    = I_PSEL && !I_PENABLE;
  wire       access   = I_PSEL && I_PENABLE && pready_r;
  wire [7:0] idx      = I_PADDR[9:2];
  wire       aligned  = (I_PADDR[11:10] == 2'h0) && (I_PADDR[1:0] == 2'h0);
  wire [3:0] slot     = cfg_slot(idx);
  wire       hit_ctrl = aligned && (idx == `CCS_IDX_CTRL);
  wire       hit_stat = aligned && (idx == `CCS_IDX_STAT);
  wire       hit_irq  = aligned && (idx == `CCS_IDX_IRQ);
  wire       hit_cfg  = aligned && slot[3];
  wire       mapped   = hit_ctrl || hit_stat || hit_irq || hit_cfg;
  wire       wr_en    = access && I_PWRITE && I_PSTRB[0];
  wire       wr_ctrl  = wr_en && hit_ctrl;
  wire       wr_stat  = wr_en && hit_stat;
  wire       wr_cfg   = wr_en && hit_cfg && ctrl_r[`CCS_CTRL_CCE];
  wire       rd_stat  = access && !I_PWRITE && hit_stat;
  wire [7:0] wbyte    = I_PWDATA[7:0];

  wire [7:0] stat_rd  = {bus_off_flag_r, warn_r, wake_r, rx_success_flag_r, tx_success_flag_r, lec_r};
  wire [7:0] irq_rd   = pend_r ? `CCS_IRQ_STATUS : `CCS_IRQ_NONE;
  wire [7:0] rd_sel   = hit_ctrl ? ctrl_r :
                        hit_stat ? stat_rd :
                        hit_irq  ? irq_rd :
                        hit_cfg  ? cfg_r[slot[2:0]] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // protocol state

  wire over_bus_off_flag = (I_EVT.tec >= `CCS_LIM_BUS_OFF_FLAG) || (I_EVT.rec >= `CCS_LIM_BUS_OFF_FLAG);
  wire over_warn = (I_EVT.tec >= `CCS_LIM_WARN) || (I_EVT.rec >= `CCS_LIM_WARN);
  wire init_now  = ctrl_r[`CCS_CTRL_INIT];
  wire in_run    = (state_r == ccs_pkg::CCS_RUN);
  wire in_rec    = (state_r == ccs_pkg::CCS_RECOVER);
  wire bus_off_flag_enter = in_run && over_bus_off_flag;
  wire rec_idle  = in_rec && I_EVT.idle11;
  wire rec_done  = rec_idle && (rcnt_r == `CCS_RECOVER_LAST);

  always_comb begin
    state_nxt = state_r;
    rcnt_nxt  = rcnt_r;
    case (state_r)
      ccs_pkg::CCS_HOLD: begin
        if (!init_now) begin
          state_nxt = ccs_pkg::CCS_SYNC;
        end
      end
      ccs_pkg::CCS_SYNC: begin
        if (init_now) begin
          state_nxt = ccs_pkg::CCS_HOLD;
        end else if (I_EVT.idle11) begin
          state_nxt = ccs_pkg::CCS_RUN;
        end
      end
      ccs_pkg::CCS_RUN: begin
        if (over_bus_off_flag) begin
          state_nxt = ccs_pkg::CCS_BUS_OFF_FLAG;
        end else if (init_now && !I_EVT.frame_active) begin
          state_nxt = ccs_pkg::CCS_HOLD;
        end
      end
      ccs_pkg::CCS_BUS_OFF_FLAG: begin
        rcnt_nxt = 7'h00;
        if (!init_now) begin
          state_nxt = ccs_pkg::CCS_RECOVER;
        end
      end
      ccs_pkg::CCS_RECOVER: begin
        if (rec_done) begin
          state_nxt = ccs_pkg::CCS_RUN;
        end else if (I_EVT.idle11) begin
          rcnt_nxt = rcnt_r + 7'h01;
        end
      end
      default: begin
        state_nxt = ccs_pkg::CCS_HOLD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and status next values

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wbyte & `CCS_CTRL_WMASK;
    end
    if (bus_off_flag_enter) begin
      ctrl_nxt[`CCS_CTRL_INIT] = 1'b1;
    end
  end

  assign bus_off_flag_nxt = bus_off_flag_enter ? 1'b1 : (rec_done ? 1'b0 : bus_off_flag_r);
  assign warn_nxt = over_warn;

  ////////////////////////////////////////////////////////////////////////////
  // wake and success flags, last error code

  wire sleep_enter = I_EVT.sleep && !sleep_d_r;
  wire sleep_exit = sleep_d_r && !I_EVT.sleep;
  wire pd_exit    = pd_d_r && !I_EVT.power_down;
  wire wake_set   = (I_EVT.sleep && I_EVT.bus_activity) || sleep_exit || pd_exit;

  assign wake_nxt = wake_set ? 1'b1 : (sleep_enter ? 1'b0 : wake_r);

  assign rx_success_flag_nxt = I_EVT.rx_ok || (wr_stat ? wbyte[`CCS_STAT_RX_SUCCESS_FLAG] : rx_success_flag_r);
  assign tx_success_flag_nxt = I_EVT.tx_ok || (wr_stat ? wbyte[`CCS_STAT_TX_SUCCESS_FLAG] : tx_success_flag_r);

  wire bit_err   = (I_EVT.err_code == `CCS_LEC_BIT1) || (I_EVT.err_code == `CCS_LEC_BIT0);
  wire err_take  = I_EVT.err_valid && !first_r && !(I_EVT.in_arbitration && bit_err);
  wire frame_ok  = I_EVT.rx_ok || I_EVT.tx_ok;
  wire lec_upd   = err_take || frame_ok || rec_idle;

  always_comb begin
    lec_nxt = lec_r;
    if (wr_stat) begin
      lec_nxt = wbyte[2:0];
    end
    if (rec_idle) begin
      lec_nxt = `CCS_LEC_BIT0;
    end else if (frame_ok) begin
      lec_nxt = `CCS_LEC_NONE;
    end else if (err_take) begin
      lec_nxt = I_EVT.err_code;
    end
  end

  assign first_nxt = I_EVT.frame_start ? 1'b0 : (first_r || err_take);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pending and gating

  wire err_evt  = ctrl_r[`CCS_CTRL_EIE] &&
                  ((bus_off_flag_nxt != bus_off_flag_r) || (warn_nxt != warn_r));
  wire stat_evt = ctrl_r[`CCS_CTRL_SIE] &&
                  (wake_set || I_EVT.rx_ok || I_EVT.tx_ok || lec_upd);

  assign pend_nxt = (err_evt || stat_evt) ? 1'b1 : (rd_stat ? 1'b0 : pend_r);

  wire run_nxt  = (state_nxt == ccs_pkg::CCS_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_r  <= `CCS_CTRL_RST;
      state_r <= ccs_pkg::CCS_HOLD;
      rcnt_r  <= 7'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      state_r <= state_nxt;
      rcnt_r  <= rcnt_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bus_off_flag_r    <= 1'b0;
      warn_r    <= 1'b0;
      wake_r    <= 1'b0;
      rx_success_flag_r    <= 1'b0;
      tx_success_flag_r    <= 1'b0;
      lec_r     <= `CCS_LEC_NONE;
      first_r   <= 1'b0;
      pend_r    <= 1'b0;
      sleep_d_r <= 1'b0;
      pd_d_r    <= 1'b0;
    end else begin
      bus_off_flag_r    <= bus_off_flag_nxt;
      warn_r    <= warn_nxt;
      wake_r    <= wake_nxt;
      rx_success_flag_r    <= rx_success_flag_nxt;
      tx_success_flag_r    <= tx_success_flag_nxt;
      lec_r     <= lec_nxt;
      first_r   <= first_nxt;
      pend_r    <= pend_nxt;
      sleep_d_r <= I_EVT.sleep;
      pd_d_r    <= I_EVT.power_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // config registers
  generate
    for (genvar g = 0; g < `CCS_CFG_NUM; g++) begin : g_cfg
      always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          cfg_r[g] <= `CCS_CFG_RST;
        end else if (wr_cfg && (slot[2:0] == 3'(g))) begin
          cfg_r[g] <= wbyte;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apb answer, one wait-free access phase
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= setup ? {24'h00_0000, rd_sel} : 32'h0000_0000;
      pslverr_r <= setup && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_r  <= 1'b0;
      tx_a_r <= 1'b1;
      tx_b_r <= 1'b0;
      core_r <= '0;
    end else begin
      irq_r  <= ctrl_nxt[`CCS_CTRL_IE] && pend_nxt;
      tx_a_r <= run_nxt ? I_EVT.tx_bit : 1'b1;
      tx_b_r <= run_nxt ? !I_EVT.tx_bit : 1'b0;
      core_r.xfer_enable   <= run_nxt && !ctrl_nxt[`CCS_CTRL_INIT];
      core_r.err_cnt_clear <= (state_r == ccs_pkg::CCS_BUS_OFF_FLAG) &&
                              (state_nxt == ccs_pkg::CCS_RECOVER);
      core_r.bus_off       <= bus_off_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drive

  assign O_PREADY   = pready_r;
  assign O_PRDATA   = prdata_r;
  assign O_PSLVERR  = pslverr_r;
  assign O_IRQ      = irq_r;
  assign O_TX_OUT_A = tx_a_r;
  assign O_TX_OUT_B = tx_b_r;
  assign O_CORE_CTL = core_r;

endmodule

`default_nettype wire

// *** verilog/ccs_pkg.sv ***
package ccs_pkg;

  typedef enum logic [2:0] {
    CCS_HOLD,
    CCS_SYNC,
    CCS_RUN,
    CCS_BUS_OFF_FLAG,
    CCS_RECOVER
  } ccs_state_t;

  // events and levels from the protocol engine
  typedef struct packed {
    logic       rx_ok;
    logic       tx_ok;
    logic       err_valid;
    logic [2:0] err_code;
    logic       in_arbitration;
    logic       frame_start;
    logic       frame_active;
    logic       idle11;
    logic       bus_activity;
    logic       sleep;
    logic       power_down;
    logic       tx_bit;
    logic [8:0] tec;
    logic [8:0] rec;
  } ccs_evt_t;

  // controls back to the protocol engine
  typedef struct packed {
    logic xfer_enable;
    logic err_cnt_clear;
    logic bus_off;
  } ccs_core_ctl_t;

endpackage

// *** verilog/ccs_regs.svh ***
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// register indices, byte address is four times the index
`define CCS_IDX_CTRL      8'h00
`define CCS_IDX_STAT      8'h01
`define CCS_IDX_IRQ       8'h5F
`define CCS_IDX_CFG0      8'h1F
`define CCS_IDX_CFG1      8'h2F
`define CCS_IDX_CFG2      8'h3F
`define CCS_IDX_CFG3      8'h4F
`define CCS_IDX_CFG4      8'h9F
`define CCS_IDX_CFG5      8'hAF
`define CCS_CFG_NUM       6

// control register fields
`define CCS_CTRL_RST      8'h01
`define CCS_CTRL_WMASK    8'h4F
`define CCS_CTRL_INIT     0
`define CCS_CTRL_IE       1
`define CCS_CTRL_SIE      2
`define CCS_CTRL_EIE      3
`define CCS_CTRL_CCE      6

// status register fields
`define CCS_STAT_RST      8'h00
`define CCS_STAT_TX_SUCCESS_FLAG     3
`define CCS_STAT_RX_SUCCESS_FLAG     4
`define CCS_STAT_WAKE     5
`define CCS_STAT_WARN     6
`define CCS_STAT_BUS_OFF_FLAG     7

// config register reset value
`define CCS_CFG_RST       8'h00

// interrupt register codes
`define CCS_IRQ_NONE      8'h00
`define CCS_IRQ_STATUS    8'h01

// last error codes
`define CCS_LEC_NONE      3'h0
`define CCS_LEC_STUFF     3'h1
`define CCS_LEC_FORM      3'h2
`define CCS_LEC_ACK       3'h3
`define CCS_LEC_BIT1      3'h4
`define CCS_LEC_BIT0      3'h5

// error counter limits and recovery count
`define CCS_LIM_BUS_OFF_FLAG      9'h100
`define CCS_LIM_WARN      9'h060
`define CCS_RECOVER_LAST  7'h7F

`endif
